// file: hw/flash_self_program_sequencer.sv
// Flash self-programming sequencer: buffer loads, page and section erase/write, CRCs.
`timescale 1ns/100ps
`default_nettype none
// -----------------------------------------------------------------------------
// -----------------------------------------------------------------------------
module flash_self_program_sequencer (
  input  wire logic                              clock,
  input  wire logic                              rst_b,
  input  wire flash_seq_pkg::nvm_req_s           req,
  input  wire logic                              store_program_instruction,
  input  wire logic                              command_execute_bit,
  input  wire logic                              change_protection_open,
  input  wire logic                              boot_locks_clear,
  input  wire logic [flash_seq_pkg::DATA_W-1:0]  flash_rdata,
  output flash_seq_pkg::flash_cmd_s              flash_cmd,
  output logic                                   busy,
  output logic                                   flash_section_busy,
  output logic                                   cpu_halt,
  output logic                                   cmd_abort,
  output logic [flash_seq_pkg::DATA_W-1:0]       crc_result
);
  import flash_seq_pkg::*;

  typedef enum logic [3:0] {IDLE, ERASE, PROG_RD, PROG_WR, WRITE_WAIT,
                            CRC_RD, CRC_WAIT, CRC_ACC, CLEAR} state_e;

  // ---------------------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------------------
  function automatic logic in_boot(input logic [PAGE_W-1:0] p);
    return p >= BOOT_FIRST_PAGE;
  endfunction

  function automatic logic [DATA_W-1:0] crc_word(input logic [DATA_W-1:0] c,
                                                 input logic [DATA_W-1:0] w);
    logic [DATA_W-1:0] r;
    r = c ^ w;
    for (int i = 0; i < DATA_W; i++) begin
      r = r[DATA_W-1] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  state_e               state_q, state_d;
  logic [WAIT_W-1:0]    wait_q, wait_d;
  logic [WORD_BITS-1:0] idx_q, idx_d;
  logic [PTR_W-1:0]     crc_addr_q, crc_addr_d;
  logic [PTR_W-1:0]     crc_end_q, crc_end_d;
  logic [DATA_W-1:0]    crc_q, crc_d;
  logic [DATA_W-1:0]    result_q, result_d;
  logic [PAGE_W-1:0]    page_q, page_d;
  logic                 do_prog_q, do_prog_d;
  logic                 sig_q, sig_d;
  logic                 halt_q, halt_d;
  logic                 sect_busy_q, sect_busy_d;
  logic                 abort_q;
  logic [PAGE_WORDS-1:0] loaded_q;
  flash_cmd_s           fcmd_q, fcmd_d;
  logic [DATA_W-1:0]    buf_rdata;

  // ---------------------------------------------------------------------------
  // Trigger decode
  // ---------------------------------------------------------------------------
  wire [6:0]        code     = req.code;
  wire [PAGE_W-1:0] ptr_page = req.pointer[PTR_W-1:WORD_BITS];
  wire              ptr_boot = in_boot(ptr_page);
  wire              idle     = (state_q == IDLE);
  wire              store_go = store_program_instruction & idle;
  wire              load_hit = store_go & (code == CMD_LOAD_BUF);
  wire              store_ok = store_go & change_protection_open;
  wire              exec_go  = command_execute_bit & idle & change_protection_open;

  wire is_app_cmd  = (code == CMD_APP_ERASE) | (code == CMD_APP_WRITE) | (code == CMD_APP_EW);
  wire is_boot_cmd = (code == CMD_BOOT_ERASE) | (code == CMD_BOOT_WRITE) | (code == CMD_BOOT_EW);
  wire is_erase    = (code == CMD_ERASE_PAGE) | (code == CMD_APP_ERASE) | (code == CMD_BOOT_ERASE);
  wire is_write    = (code == CMD_WRITE_PAGE) | (code == CMD_APP_WRITE) | (code == CMD_BOOT_WRITE);
  wire is_ew       = (code == CMD_EW_PAGE) | (code == CMD_APP_EW) | (code == CMD_BOOT_EW);
  wire sect_bad    = (is_app_cmd & ptr_boot) | (is_boot_cmd & ~ptr_boot);
  wire page_req    = store_ok & (is_erase | is_write | is_ew);
  wire page_go     = page_req & ~sect_bad;
  wire app_req     = store_ok & (code == CMD_ERASE_APP);
  wire app_go      = app_req & ~ptr_boot;
  wire sig_erase   = store_ok & (code == CMD_SIG_ERASE);
  wire sig_write   = store_ok & (code == CMD_SIG_WRITE);
  wire range_cmd   = exec_go & (code == CMD_RANGE_CRC);
  wire [PTR_W-1:0] range_lo = req.start_addr[BADDR_W-1:1];
  wire [PTR_W-1:0] range_hi = req.end_addr[BADDR_W-1:1];
  wire range_bad   = ~boot_locks_clear | (range_hi < range_lo);
  wire range_go    = range_cmd & ~range_bad;
  wire sect_crc    = exec_go & ((code == CMD_APP_CRC) | (code == CMD_BOOT_CRC));
  wire abort_d     = (page_req & sect_bad) | (app_req & ptr_boot) | (range_cmd & range_bad);
  wire erase_start = (page_go & (is_erase | is_ew)) | app_go | sig_erase;
  wire write_start = (page_go & is_write) | sig_write;
  // Page commands halt the CPU only when they touch the boot section.
  wire start_halt  = (page_go & ptr_boot) | app_go | sig_erase | sig_write;
  wire [DATA_W-1:0] prog_word = loaded_q[idx_q] ? buf_rdata : ERASED_WORD;
  wire [PTR_W-1:0]  app_end   = {BOOT_FIRST_PAGE, {WORD_BITS{1'b0}}} - PTR_W'(1);
  wire [PTR_W-1:0]  boot_lo   = {BOOT_FIRST_PAGE, {WORD_BITS{1'b0}}};
  wire [DATA_W-1:0] crc_next  = crc_word(crc_q, flash_rdata);

  // ---------------------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------------------
  always_comb begin
    state_d    = state_q;
    wait_d     = wait_q;
    idx_d      = idx_q;
    crc_addr_d = crc_addr_q;
    crc_end_d  = crc_end_q;
    crc_d      = crc_q;
    result_d   = result_q;
    page_d     = page_q;
    do_prog_d  = do_prog_q;
    sig_d      = sig_q;
    halt_d     = halt_q;
    sect_busy_d = sect_busy_q;
    fcmd_d     = '0;
    unique case (state_q)
      IDLE: begin
        page_d    = sig_erase | sig_write ? '0 : ptr_page;
        sig_d     = sig_erase | sig_write;
        do_prog_d = page_go & is_ew;
        halt_d    = start_halt | range_go | sect_crc;
        sect_busy_d = erase_start | write_start;
        idx_d     = '0;
        if (erase_start) begin
          state_d        = ERASE;
          wait_d         = (app_go ? APP_ERASE_CYC : PAGE_ERASE_CYC) - WAIT_W'(1);
          fcmd_d.erase   = 1'b1;
          fcmd_d.app_all = app_go;
          fcmd_d.sig_row = sig_erase;
          fcmd_d.page    = sig_erase ? '0 : ptr_page;
        end else if (write_start) begin
          state_d = PROG_RD;
        end else if (range_go | sect_crc) begin
          state_d    = CRC_RD;
          crc_d      = CRC_INIT;
          crc_addr_d = range_go ? range_lo : (code == CMD_APP_CRC ? '0 : boot_lo);
          crc_end_d  = range_go ? range_hi : (code == CMD_APP_CRC ? app_end : '1);
        end
      end
      ERASE: begin
        if (wait_q == '0) begin
          if (do_prog_q) begin
            state_d = PROG_RD;
          end else begin
            state_d     = IDLE;
            halt_d      = 1'b0;
            sect_busy_d = 1'b0;
          end
        end else begin
          wait_d = wait_q - WAIT_W'(1);
        end
      end
      PROG_RD: begin
        state_d = PROG_WR;
      end
      PROG_WR: begin
        fcmd_d.prog    = 1'b1;
        fcmd_d.sig_row = sig_q;
        fcmd_d.page    = page_q;
        fcmd_d.word    = idx_q;
        fcmd_d.wdata   = prog_word;
        if (idx_q == WORD_BITS'(PAGE_WORDS - 1)) begin
          state_d = WRITE_WAIT;
          wait_d  = PAGE_WRITE_CYC - WAIT_W'(1);
        end else begin
          idx_d   = idx_q + WORD_BITS'(1);
          state_d = PROG_RD;
        end
      end
      WRITE_WAIT: begin
        if (wait_q == '0) begin
          state_d     = sig_q ? CLEAR : IDLE;
          halt_d      = 1'b0;
          sect_busy_d = 1'b0;
        end else begin
          wait_d = wait_q - WAIT_W'(1);
        end
      end
      CLEAR: begin
        state_d = IDLE;
      end
      CRC_RD: begin
        fcmd_d.rd   = 1'b1;
        fcmd_d.page = crc_addr_q[PTR_W-1:WORD_BITS];
        fcmd_d.word = crc_addr_q[WORD_BITS-1:0];
        state_d     = CRC_WAIT;
      end
      CRC_WAIT: begin
        state_d = CRC_ACC;
      end
      CRC_ACC: begin
        crc_d = crc_next;
        if (crc_addr_q == crc_end_q) begin
          result_d = crc_next;
          state_d  = IDLE;
          halt_d   = 1'b0;
        end else begin
          crc_addr_d = crc_addr_q + PTR_W'(1);
          state_d    = CRC_RD;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_q    <= IDLE;
      wait_q     <= '0;
      idx_q      <= '0;
      crc_addr_q <= '0;
      crc_end_q  <= '0;
      crc_q      <= '0;
      result_q   <= '0;
      page_q     <= '0;
      do_prog_q  <= 1'b0;
      sig_q      <= 1'b0;
      halt_q      <= 1'b0;
      sect_busy_q <= 1'b0;
      abort_q    <= 1'b0;
      fcmd_q     <= '0;
    end else begin
      state_q    <= state_d;
      wait_q     <= wait_d;
      idx_q      <= idx_d;
      crc_addr_q <= crc_addr_d;
      crc_end_q  <= crc_end_d;
      crc_q      <= crc_d;
      result_q   <= result_d;
      page_q     <= page_d;
      do_prog_q  <= do_prog_d;
      sig_q      <= sig_d;
      halt_q     <= halt_d;
      sect_busy_q <= sect_busy_d;
      abort_q    <= abort_d;
      fcmd_q     <= fcmd_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Page buffer
  // ---------------------------------------------------------------------------
  // The loaded map stands in for a bulk erase of the storage itself.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      loaded_q <= '0;
    end else if (state_q == CLEAR) begin
      loaded_q <= '0;
    end else if (load_hit) begin
      loaded_q[req.pointer[WORD_BITS-1:0]] <= 1'b1;
    end
  end

  page_buffer_mem u_buf (
    .clock (clock),
    .rst_b (rst_b),
    .we    (load_hit),
    .waddr (req.pointer[WORD_BITS-1:0]),
    .wdata (req.data_pair),
    .raddr (idx_q),
    .rdata (buf_rdata)
  );

  assign flash_cmd          = fcmd_q;
  assign busy               = ~idle;
  assign flash_section_busy = sect_busy_q;
  assign cpu_halt           = halt_q;
  assign cmd_abort          = abort_q;
  assign crc_result         = result_q;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  a_load_unprotected: assert property (load_hit |=> loaded_q[$past(req.pointer[WORD_BITS-1:0])])
    else $error("buffer load not recorded");
  a_unloaded_ones: assert property (state_q == PROG_WR && !loaded_q[idx_q] |=> fcmd_q.wdata == 16'hffff)
    else $error("unloaded word not programmed as ones");
  a_erase_page: assert property (page_go && is_erase |=> fcmd_q.erase && fcmd_q.page == $past(ptr_page))
    else $error("page erase targets wrong page");
  a_busy_hold: assert property (fcmd_q.erase && !fcmd_q.sig_row |-> busy && flash_section_busy)
    else $error("busy flags not held during erase");
  a_write_page: assert property (state_q == PROG_WR |=> fcmd_q.prog && fcmd_q.page == page_q)
    else $error("page write targets wrong page");
  a_crc_halt: assert property (range_go || sect_crc |=> busy && cpu_halt ##1 busy && cpu_halt)
    else $error("CRC does not halt CPU");
  a_lock_abort: assert property (range_cmd && !boot_locks_clear |=> cmd_abort && !busy)
    else $error("range CRC not aborted on locks");
  a_app_erase: assert property (app_go |=> fcmd_q.app_all && cpu_halt && busy)
    else $error("application erase malformed");
  a_sect_abort: assert property (page_req && sect_bad |=> cmd_abort && !busy)
    else $error("wrong-section page not aborted");
  a_protect_needed: assert property (store_go && !change_protection_open && code != CMD_LOAD_BUF |=> !busy)
    else $error("unprotected trigger started a command");
  a_busy_ignores: assert property (busy && state_q != CLEAR && store_program_instruction |=> $stable(loaded_q))
    else $error("trigger accepted while busy");
  a_clear_runs: assert property (state_q == CLEAR |-> busy && !cpu_halt && !flash_section_busy)
    else $error("buffer clear stage halts CPU");

  c_erase_write: cover property (page_go && is_ew);
  c_range_crc: cover property (state_q == CRC_ACC && crc_addr_q == crc_end_q);
  c_sig_write: cover property (state_q == CLEAR);
endmodule
`default_nettype wire

// file: hw/flash_seq_pkg.sv
// Constants, command codes and carrier types for the flash self-programming sequencer.
package flash_seq_pkg;

  // ----------------------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------------------
  localparam int WORD_BITS  = 6;
  localparam int PAGE_WORDS = 64;
  localparam int PAGE_W     = 10;
  localparam int PTR_W      = 16;
  localparam int BADDR_W    = 17;
  localparam int DATA_W     = 16;
  localparam int WAIT_W     = 12;
  // Pages from here upward form the boot section.
  localparam logic [PAGE_W-1:0] BOOT_FIRST_PAGE = 10'h3c0;
  localparam logic [DATA_W-1:0] ERASED_WORD     = 16'hffff;

  // ----------------------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------------------
  localparam logic [6:0] CMD_LOAD_BUF    = 7'h23;
  localparam logic [6:0] CMD_ERASE_PAGE  = 7'h2b;
  localparam logic [6:0] CMD_WRITE_PAGE  = 7'h2e;
  localparam logic [6:0] CMD_EW_PAGE     = 7'h2f;
  localparam logic [6:0] CMD_RANGE_CRC   = 7'h3a;
  localparam logic [6:0] CMD_ERASE_APP   = 7'h20;
  localparam logic [6:0] CMD_APP_ERASE   = 7'h22;
  localparam logic [6:0] CMD_APP_WRITE   = 7'h24;
  localparam logic [6:0] CMD_APP_EW      = 7'h25;
  localparam logic [6:0] CMD_APP_CRC     = 7'h38;
  localparam logic [6:0] CMD_BOOT_ERASE  = 7'h2a;
  localparam logic [6:0] CMD_BOOT_WRITE  = 7'h2c;
  localparam logic [6:0] CMD_BOOT_EW     = 7'h2d;
  localparam logic [6:0] CMD_BOOT_CRC    = 7'h39;
  localparam logic [6:0] CMD_SIG_ERASE   = 7'h18;
  localparam logic [6:0] CMD_SIG_WRITE   = 7'h1a;

  // ----------------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int PAGE_ERASE_US = 4;
  localparam int PAGE_WRITE_US = 4;
  localparam int APP_ERASE_US  = 40;
  localparam logic [WAIT_W-1:0] PAGE_ERASE_CYC = WAIT_W'(PAGE_ERASE_US * 1000 / CLK_PERIOD_NS);
  localparam logic [WAIT_W-1:0] PAGE_WRITE_CYC = WAIT_W'(PAGE_WRITE_US * 1000 / CLK_PERIOD_NS);
  localparam logic [WAIT_W-1:0] APP_ERASE_CYC  = WAIT_W'(APP_ERASE_US * 1000 / CLK_PERIOD_NS);

  localparam logic [DATA_W-1:0] CRC_INIT = 16'hffff;
  localparam logic [DATA_W-1:0] CRC_POLY = 16'h1021;

  // ----------------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic [6:0]         code;
    logic [PTR_W-1:0]   pointer;
    logic [DATA_W-1:0]  data_pair;
    logic [BADDR_W-1:0] start_addr;
    logic [BADDR_W-1:0] end_addr;
  } nvm_req_s;

  typedef struct packed {
    logic                 erase;
    logic                 prog;
    logic                 rd;
    logic                 app_all;
    logic                 sig_row;
    logic [PAGE_W-1:0]    page;
    logic [WORD_BITS-1:0] word;
    logic [DATA_W-1:0]    wdata;
  } flash_cmd_s;

endpackage

// file: hw/page_buffer_mem.sv
// Flash page buffer storage with a registered read port.
`timescale 1ns/100ps
`default_nettype none
module page_buffer_mem (
  input  wire logic                                   clock,
  input  wire logic                                   rst_b,
  input  wire logic                                   we,
  input  wire logic [flash_seq_pkg::WORD_BITS-1:0]    waddr,
  input  wire logic [flash_seq_pkg::DATA_W-1:0]       wdata,
  input  wire logic [flash_seq_pkg::WORD_BITS-1:0]    raddr,
  output logic      [flash_seq_pkg::DATA_W-1:0]       rdata
);
  import flash_seq_pkg::*;

  logic [DATA_W-1:0] mem [PAGE_WORDS];

  always_ff @(posedge clock) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= '0;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule
`default_nettype wire

// file: verification/flash_array_model.sv
// Behavioural flash array and user signature row that answer the sequencer's pulses.
`timescale 1ns/100ps
`default_nettype none
module flash_array_model (
  input  wire logic                        clock,
  input  wire flash_seq_pkg::flash_cmd_s   flash_cmd,
  output logic [flash_seq_pkg::DATA_W-1:0] flash_rdata
);
  import flash_seq_pkg::*;
  logic [DATA_W-1:0] mem [int];
  logic [DATA_W-1:0] sig [int];
  // Words never touched read as an address pattern, so a wrong word address shows in a CRC.
  function automatic logic [DATA_W-1:0] peek(input int a);
    return mem.exists(a) ? mem[a] : DATA_W'(a * 7 + 3);
  endfunction
  function automatic logic [DATA_W-1:0] sig_peek(input int a);
    return sig.exists(a) ? sig[a] : 16'h0000;
  endfunction
  initial flash_rdata = 16'h0000;
  always @(posedge clock) begin
    int a;
    a = {flash_cmd.page, flash_cmd.word};
    if (flash_cmd.erase && flash_cmd.sig_row) begin
      for (int i = 0; i < PAGE_WORDS; i++) sig[i] = ERASED_WORD;
    end else if (flash_cmd.erase && flash_cmd.app_all) begin
      for (int i = 0; i < int'(BOOT_FIRST_PAGE) * PAGE_WORDS; i++) mem[i] = ERASED_WORD;
    end else if (flash_cmd.erase) begin
      for (int i = 0; i < PAGE_WORDS; i++) mem[int'(flash_cmd.page) * PAGE_WORDS + i] = ERASED_WORD;
    end
    // Programming can only clear bits, as real flash cells do.
    if (flash_cmd.prog && flash_cmd.sig_row) sig[flash_cmd.word] = sig_peek(flash_cmd.word) & flash_cmd.wdata;
    else if (flash_cmd.prog) mem[a] = peek(a) & flash_cmd.wdata;
    if (flash_cmd.rd) flash_rdata <= peek(a);
  end
endmodule
`default_nettype wire

// file: verification/flash_self_program_sequencer_tb.sv
// Self-checking testbench for the flash self-programming sequencer.
`timescale 1ns/100ps
`default_nettype none
module flash_self_program_sequencer_tb;
  import flash_seq_pkg::*;
  logic clock = 1'b0, rst_b = 1'b0, store_pulse = 1'b0, exec_pulse = 1'b0, prot = 1'b0, locks = 1'b1;
  nvm_req_s          req = '0;
  flash_cmd_s        fcmd;
  logic [DATA_W-1:0] rdata, crc;
  logic              busy, sect_busy, halt, abort_p;
  logic [DATA_W-1:0] buf_exp [PAGE_WORDS];
  logic [6:0]        code;
  int errors = 0, checks_done = 0, seed = 18, cyc, pg;
  bit halt_seen, fb_seen, run_free, boot;
  int pages [3];
  always #5 clock = ~clock;
  flash_self_program_sequencer i_dut (.clock(clock), .rst_b(rst_b), .store_program_instruction(store_pulse),
    .req(req), .command_execute_bit(exec_pulse), .change_protection_open(prot), .boot_locks_clear(locks),
    .flash_rdata(rdata), .flash_cmd(fcmd), .busy(busy), .flash_section_busy(sect_busy), .cpu_halt(halt),
    .cmd_abort(abort_p), .crc_result(crc));
  flash_array_model i_flash (.clock(clock), .flash_cmd(fcmd), .flash_rdata(rdata));
  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic trig(input logic [6:0] c, input logic [PTR_W-1:0] p, input bit exe, input bit pr);
    @(negedge clock);
    req.code = c;
    req.pointer = p;
    prot = pr;
    store_pulse = !exe;
    exec_pulse = exe;
    @(negedge clock);
    store_pulse = 1'b0;
    exec_pulse = 1'b0;
    prot = 1'b0;
  endtask
  task automatic wait_idle();
    cyc = 0; halt_seen = 0; fb_seen = 0; run_free = 0;
    while (busy === 1'b1 && cyc < 20000) begin
      run_free |= halt_seen && !halt;
      halt_seen |= halt;
      fb_seen |= sect_busy;
      cyc++;
      @(negedge clock);
    end
    if (cyc >= 20000) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, 1, 0);
      print_verdict();
    end
  endtask
  task automatic load(input int w);
    req.data_pair = 16'($random(seed));
    buf_exp[w] = req.data_pair;
    trig(CMD_LOAD_BUF, PTR_W'(w), 1'b0, 1'b0);
  endtask
  task automatic page_check(input int p, input bit erased);
    for (int w = 0; w < PAGE_WORDS; w++) check(i_flash.peek(p * PAGE_WORDS + w), erased ? ERASED_WORD : buf_exp[w]);
  endtask
  function automatic logic [DATA_W-1:0] crc_ref(input int a, input int b);
    logic [DATA_W-1:0] c = CRC_INIT;
    for (int i = a; i <= b; i++) begin
      c ^= i_flash.peek(i);
      for (int j = 0; j < 16; j++) c = c[15] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction
  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (12) @(negedge clock);
    rst_b = 1'b1;
    check({busy, sect_busy, halt, abort_p, crc}, 0);
    $display("test reset done");
    for (int w = 0; w < PAGE_WORDS; w++) buf_exp[w] = ERASED_WORD;
    for (int k = 0; k < 9; k++) load(($random(seed) & 32'h3f));
    pages[0] = ($random(seed) & 32'h1ff) + 1;
    // Kept below the boot section so that the application-section commands on it stay legal.
    pages[1] = pages[0] + 400;
    pages[2] = int'(BOOT_FIRST_PAGE) + ($random(seed) & 32'h3f);
    // Erase-write, then erase, then write, each in general, application and boot form.
    for (int k = 0; k < 9; k++) begin
      code = k < 3 ? (k == 0 ? CMD_EW_PAGE : k == 1 ? CMD_APP_EW : CMD_BOOT_EW)
           : k < 6 ? (k == 3 ? CMD_ERASE_PAGE : k == 4 ? CMD_APP_ERASE : CMD_BOOT_ERASE)
           : (k == 6 ? CMD_WRITE_PAGE : k == 7 ? CMD_APP_WRITE : CMD_BOOT_WRITE);
      pg = pages[k % 3];
      trig(code, {PAGE_W'(pg), 6'($random(seed))}, 1'b0, 1'b1);
      check({busy, abort_p}, 2'b10);
      wait_idle();
      check({fb_seen, halt_seen}, {1'b1, k % 3 == 2});
      if (k >= 3 && k < 6) check(cyc >= PAGE_ERASE_CYC && cyc <= PAGE_ERASE_CYC + 1, 1);
      page_check(pg, k >= 3 && k < 6);
    end
    $display("test page commands done");
    for (int k = 0; k < 7; k++) begin
      boot = k < 4;
      code = k == 0 ? CMD_APP_ERASE : k == 1 ? CMD_APP_WRITE : k == 2 ? CMD_APP_EW : k == 3 ? CMD_ERASE_APP
           : k == 4 ? CMD_BOOT_ERASE : k == 5 ? CMD_BOOT_WRITE : CMD_BOOT_EW;
      trig(code, {PAGE_W'(boot ? pages[2] : pages[0]), 6'h00}, 1'b0, 1'b1);
      check({abort_p, busy}, 2'b10);
    end
    trig(CMD_ERASE_PAGE, {PAGE_W'(pages[0]), 6'h00}, 1'b0, 1'b0);
    check({abort_p, busy}, 2'b00);
    $display("test refusals done");
    trig(CMD_ERASE_PAGE, {PAGE_W'(pages[0]), 6'h00}, 1'b0, 1'b1);
    trig(CMD_ERASE_PAGE, {PAGE_W'(pages[1]), 6'h00}, 1'b0, 1'b1);
    wait_idle();
    page_check(pages[0], 1);
    page_check(pages[1], 0);
    $display("test busy refusal done");
    pg = $random(seed) & 32'h7fff;
    req.start_addr = BADDR_W'(pg * 2);
    req.end_addr = BADDR_W'(pg * 2 + 15);
    trig(CMD_RANGE_CRC, 16'h0000, 1'b1, 1'b1);
    wait_idle();
    check({halt_seen, crc}, {1'b1, crc_ref(pg, pg + 7)});
    locks = 1'b0;
    trig(CMD_RANGE_CRC, 16'h0000, 1'b1, 1'b1);
    check({abort_p, busy}, 2'b10);
    locks = 1'b1;
    // The application CRC walks 61440 words, too long for this run, so only the boot one is run.
    trig(CMD_BOOT_CRC, 16'h0000, 1'b1, 1'b1);
    wait_idle();
    check({halt_seen, crc}, {1'b1, crc_ref(32'hf000, 32'hffff)});
    $display("test crc done");
    trig(CMD_ERASE_APP, {PAGE_W'(pages[1]), 6'h15}, 1'b0, 1'b1);
    wait_idle();
    check({halt_seen, cyc >= APP_ERASE_CYC}, 2'b11);
    page_check(pages[0], 1);
    page_check(pages[1], 1);
    trig(CMD_SIG_ERASE, 16'h0000, 1'b0, 1'b1);
    wait_idle();
    check(halt_seen, 1);
    for (int w = 0; w < PAGE_WORDS; w++) check(i_flash.sig_peek(w), ERASED_WORD);
    trig(CMD_SIG_WRITE, 16'h0000, 1'b0, 1'b1);
    wait_idle();
    check({halt_seen, run_free}, 2'b11);
    for (int w = 0; w < PAGE_WORDS; w++) check(i_flash.sig_peek(w), buf_exp[w]);
    trig(CMD_WRITE_PAGE, {PAGE_W'(pages[1]), 6'h00}, 1'b0, 1'b1);
    wait_idle();
    page_check(pages[1], 1);
    $display("test section and signature done");
    // The application CRC is too long to finish here, so its start is checked and a reset cuts it off.
    trig(CMD_APP_CRC, 16'h0000, 1'b1, 1'b1);
    check({busy, halt}, 2'b11);
    @(negedge clock);
    check({fcmd.rd, fcmd.page, fcmd.word}, {1'b1, 16'h0000});
    rst_b = 1'b0;
    repeat (2) @(negedge clock);
    rst_b = 1'b1;
    check({busy, sect_busy, halt, abort_p, crc}, 0);
    trig(CMD_ERASE_PAGE, {PAGE_W'(pages[0]), 6'h00}, 1'b0, 1'b1);
    check({busy, sect_busy, abort_p}, 3'b110);
    wait_idle();
    page_check(pages[0], 1);
    $display("test application crc and mid-run reset done");
    print_verdict();
  end
endmodule
`default_nettype wire
